/* src/ucs_flags.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module ucs_flags
    import ucs_pkg::*;
#(
    parameter int AW = 12,
    parameter int DW = 16
)
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // Register port
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rdata,
    // Configuration from the rest of the serial unit
    input  wire logic          sync_mode,
    input  wire logic          loopback,
    input  wire logic          flow_gate_enable,
    input  wire logic          loop_cts,
    // Receiver and transmitter activity
    input  wire logic          rx_busy,
    input  wire logic          tx_busy,
    input  wire logic          rx_char_done,
    input  wire logic          rx_start_seen,
    input  wire logic          rx_frame_err,
    input  wire logic          rx_parity_err,
    input  wire logic          rx_noise,
    // Pins
    input  wire logic          receive_pin,
    input  wire logic          cts_pin,
    output logic               serial_clk,
    // Outputs to the rest of the unit
    output logic      [DW-1:0] baud_divider,
    output logic               cts_level,
    output logic               cts_gate,
    output logic               irq_request
);

    typedef struct packed {
        logic          continuous_clock;
        logic          auto_stop_free_clock;
        logic          rate_learn_enable;
        logic [DW-1:0] divider;
        logic [31:0]   ien;
        logic          cts_prev;
        logic          cts_changed;
        logic          start_flag;
        logic          frame_err;
        logic          parity_err;
        logic          noise_err;
        logic          rate_learn_error;
        logic          rx_quiet;
        logic          tx_quiet;
        logic [DW-1:0] clk_count;
        logic          sclk;
        logic [31:0]   rdata;
        logic          irq;
    } ucs_state_t;

    ucs_state_t s_q;
    ucs_state_t s_d;

    logic          cts_synced;
    logic          rl_done;
    logic          rl_error;
    logic [DW-1:0] rl_value;
    logic          clk_active;
    logic [31:0]   status_word;
    logic          wr_control;
    logic          wr_flags;
    logic          wr_ien_set;
    logic          wr_ien_clr;
    logic          wr_divider;

    // Address match shared by every register
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [11:0]   off);
        hit = (a == AW'(off));
    endfunction

    // Pin sampled through two flops before any use
    ucs_sync u_cts_sync (
        .mclk (mclk),
        .rst_n(rst_n),
        .din  (cts_pin),
        .dout (cts_synced)
    );

    ucs_rate_learn #(
        .DW(DW)
    ) u_rate_learn (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .enable     (s_q.rate_learn_enable),
        .receive_pin(receive_pin),
        .done       (rl_done),
        .error      (rl_error),
        .measured   (rl_value)
    );

    // Looped value replaces the pin in loopback
    assign cts_level = loopback ? loop_cts : cts_synced;
    assign cts_gate  = flow_gate_enable & cts_level;

    // Clock runs free or only around a character
    assign clk_active = sync_mode &
                        (s_q.continuous_clock | tx_busy | rx_busy);

    assign wr_control = reg_wr & hit(reg_addr, UCS_OFF_CONTROL);
    assign wr_flags   = reg_wr & hit(reg_addr, UCS_OFF_FLAGS);
    assign wr_ien_set = reg_wr & hit(reg_addr, UCS_OFF_IEN_SET);
    assign wr_ien_clr = reg_wr & hit(reg_addr, UCS_OFF_IEN_CLR);
    assign wr_divider = reg_wr & hit(reg_addr, UCS_OFF_DIVIDER);

    // Status word; level bits read registered copies of the levels
    always_comb
    begin
        status_word                     = '0;
        status_word[UCS_ST_RX_QUIET]    = s_q.rx_quiet;
        status_word[UCS_ST_TX_QUIET]    = s_q.tx_quiet;
        status_word[UCS_ST_CTS_LEVEL]   = s_q.cts_prev;
        status_word[UCS_ST_CTS_CHANGED] = s_q.cts_changed;
        status_word[UCS_ST_START]       = s_q.start_flag;
        status_word[UCS_ST_FRAME_ERR]   = s_q.frame_err;
        status_word[UCS_ST_PARITY_ERR]  = s_q.parity_err;
        status_word[UCS_ST_NOISE]       = s_q.noise_err;
        status_word[UCS_ST_RATE_ERR]    = s_q.rate_learn_error;
    end

    always_comb
    begin
        s_d = s_q;

        // Control register write; reserved bits are dropped
        if (wr_control)
        begin
            s_d.continuous_clock     = reg_wdata[UCS_CTL_CONT_CLK];
            s_d.auto_stop_free_clock = reg_wdata[UCS_CTL_AUTO_STOP];
            s_d.rate_learn_enable    = reg_wdata[UCS_CTL_RATE_LEARN];
        end

        // Both bits drop together after a whole character
        if (rx_char_done && s_q.auto_stop_free_clock)
        begin
            s_d.continuous_clock     = 1'b0;
            s_d.auto_stop_free_clock = 1'b0;
        end

        if (wr_divider)
            s_d.divider = reg_wdata[DW-1:0];

        // Measured bit time loads the divider
        if (rl_done)
            s_d.divider = rl_value;

        // Mode ends itself on result or on time-out
        if (rl_done || rl_error)
            s_d.rate_learn_enable = 1'b0;

        // Enables: set and clear registers, read-only flags other than bit 3 masked
        if (wr_ien_set)
            s_d.ien = s_q.ien | (reg_wdata & UCS_IEN_MASK);
        if (wr_ien_clr)
            s_d.ien = s_q.ien & ~reg_wdata;

        // Writing 1 clears, 0 keeps; a new event wins over the clear
        if (wr_flags && reg_wdata[UCS_ST_CTS_CHANGED])
            s_d.cts_changed = 1'b0;
        if (wr_flags && reg_wdata[UCS_ST_START])
            s_d.start_flag = 1'b0;
        if (wr_flags && reg_wdata[UCS_ST_FRAME_ERR])
            s_d.frame_err = 1'b0;
        if (wr_flags && reg_wdata[UCS_ST_PARITY_ERR])
            s_d.parity_err = 1'b0;
        if (wr_flags && reg_wdata[UCS_ST_NOISE])
            s_d.noise_err = 1'b0;
        if (wr_flags && reg_wdata[UCS_ST_RATE_ERR])
            s_d.rate_learn_error = 1'b0;

        // Change of the clear-to-send level
        s_d.cts_prev = cts_level;
        if (cts_level != s_q.cts_prev)
            s_d.cts_changed = 1'b1;

        if (rx_start_seen)
            s_d.start_flag = 1'b1;
        // Sticky until software clears them
        if (rx_frame_err)
            s_d.frame_err = 1'b1;
        if (rx_parity_err)
            s_d.parity_err = 1'b1;
        if (rx_noise)
            s_d.noise_err = 1'b1;
        if (rl_error)
            s_d.rate_learn_error = 1'b1;

        // Quiet flags are the inverse of activity
        s_d.rx_quiet = ~rx_busy;
        s_d.tx_quiet = ~tx_busy;

        // Serial clock divider; idles low when not allowed to run
        if (!clk_active)
        begin
            s_d.clk_count = '0;
            s_d.sclk      = 1'b0;
        end
        else if (s_q.clk_count >= s_q.divider)
        begin
            s_d.clk_count = '0;
            s_d.sclk      = ~s_q.sclk;
        end
        else
            s_d.clk_count = s_q.clk_count + 1'b1;

        // Read data, valid in the cycle after the strobe
        s_d.rdata = '0;
        if (reg_rd)
        begin
            if (hit(reg_addr, UCS_OFF_CONTROL))
            begin
                s_d.rdata[UCS_CTL_CONT_CLK]   = s_q.continuous_clock;
                s_d.rdata[UCS_CTL_AUTO_STOP]  = s_q.auto_stop_free_clock;
                s_d.rdata[UCS_CTL_RATE_LEARN] = s_q.rate_learn_enable;
            end
            else if (hit(reg_addr, UCS_OFF_FLAGS))
                s_d.rdata = status_word;
            else if (hit(reg_addr, UCS_OFF_IEN_SET))
                s_d.rdata = s_q.ien;
            else if (hit(reg_addr, UCS_OFF_DIVIDER))
                s_d.rdata = 32'(s_q.divider);
            else
                s_d.rdata = '0;
        end

        // Enabled flags raise the request
        s_d.irq = |(status_word & s_q.ien);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.continuous_clock     <= UCS_RST_CONT_CLK;
            s_q.auto_stop_free_clock <= UCS_RST_AUTO_STOP;
            s_q.rate_learn_enable    <= UCS_RST_RATE_LEARN;
            s_q.divider              <= DW'(UCS_RST_DIVIDER);
            s_q.ien                  <= '0;
            s_q.cts_prev             <= 1'b0;
            s_q.cts_changed          <= UCS_RST_FLAG;
            s_q.start_flag           <= UCS_RST_FLAG;
            s_q.frame_err            <= UCS_RST_FLAG;
            s_q.parity_err           <= UCS_RST_FLAG;
            s_q.noise_err            <= UCS_RST_FLAG;
            s_q.rate_learn_error     <= UCS_RST_FLAG;
            s_q.rx_quiet             <= UCS_RST_QUIET;
            s_q.tx_quiet             <= UCS_RST_QUIET;
            s_q.clk_count            <= '0;
            s_q.sclk                 <= 1'b0;
            s_q.rdata                <= '0;
            s_q.irq                  <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata    = s_q.rdata;
    assign serial_clk   = s_q.sclk;
    assign baud_divider = s_q.divider;
    assign irq_request  = s_q.irq;

endmodule

/* src/ucs_pkg.sv */
// How it works
// - Sync mode, bit 8 clear: serial clock toggles only around a character.
// - Sync mode, free clock bit 8 set: serial clock runs without pause.
// - Auto-stop bit 9: a received character clears bits 8 and 9 together.
// - Rate-learn bit 16: time first start bit, load baud divider with it.
// - Rate-learn bit clears itself on finish or on rate-learn error.
// - Writing 1 clears a clearable status flag; writing 0 leaves it.
// - Noise, parity, framing flags set on detection, stay until cleared.
// - Read-only flags other than bit 3 are masked through the enable set register.
// - Status bit 1 reads 0 while receiving, 1 otherwise, resets to 1.
// - Status bit 3 reads 0 while sending, 1 otherwise, resets to 1.
// - Status bit 4 shows clear-to-send level regardless of flow gate enable.
// - Clear-to-send level comes from the pin, or looped value in loopback.
// - Status bit 5 sets on clear-to-send change, resets 0, write 1 clears.
// - Framing error flag bit 13 sets when a character lacks its stop bit.
// - Rate-learn error bit 16 sets when the measure count hits its limit.
package ucs_pkg;

    // Register byte offsets
    localparam logic [11:0] UCS_OFF_CONTROL  = 12'h004;
    localparam logic [11:0] UCS_OFF_FLAGS    = 12'h008;
    localparam logic [11:0] UCS_OFF_IEN_SET  = 12'h00c;
    localparam logic [11:0] UCS_OFF_IEN_CLR  = 12'h010;
    localparam logic [11:0] UCS_OFF_DIVIDER  = 12'h020;

    // Control register fields
    localparam int UCS_CTL_CONT_CLK   = 8;
    localparam int UCS_CTL_AUTO_STOP  = 9;
    localparam int UCS_CTL_RATE_LEARN = 16;

    // Status register fields
    localparam int UCS_ST_RX_QUIET    = 1;
    localparam int UCS_ST_TX_QUIET    = 3;
    localparam int UCS_ST_CTS_LEVEL   = 4;
    localparam int UCS_ST_CTS_CHANGED = 5;
    localparam int UCS_ST_START       = 12;
    localparam int UCS_ST_FRAME_ERR   = 13;
    localparam int UCS_ST_PARITY_ERR  = 14;
    localparam int UCS_ST_NOISE       = 15;
    localparam int UCS_ST_RATE_ERR    = 16;

    // Flags that writing 1 clears
    localparam logic [31:0] UCS_W1C_MASK = 32'h0001_f020;
    // Flags with an interrupt enable
    localparam logic [31:0] UCS_IEN_MASK = 32'h0001_f028;

    // Reset values
    localparam logic        UCS_RST_CONT_CLK   = 1'b0;
    localparam logic        UCS_RST_AUTO_STOP  = 1'b0;
    localparam logic        UCS_RST_RATE_LEARN = 1'b0;
    localparam logic        UCS_RST_QUIET      = 1'b1;
    localparam logic        UCS_RST_FLAG       = 1'b0;
    localparam logic [15:0] UCS_RST_DIVIDER    = 16'h0000;

    // Synchroniser depth
    localparam int UCS_SYNC_STAGES = 2;

endpackage

/* src/ucs_rate_learn.sv */
`timescale 1ns/1ps
module ucs_rate_learn
    import ucs_pkg::*;
#(
    parameter int DW = 16
)
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // Control
    input  wire logic          enable,
    input  wire logic          receive_pin,
    // Result
    output logic               done,
    output logic               error,
    output logic [DW-1:0]      measured
);

    typedef enum logic [1:0] {
        UCS_RL_WAIT_HIGH,
        UCS_RL_WAIT_LOW,
        UCS_RL_MEASURE
    } ucs_rl_state_t;

    typedef struct packed {
        ucs_rl_state_t state;
        logic [DW-1:0] count;
        logic          done;
        logic          error;
        logic [DW-1:0] value;
    } ucs_rl_t;

    ucs_rl_t r_q;
    ucs_rl_t r_d;

    always_comb
    begin
        r_d       = r_q;
        r_d.done  = 1'b0;
        r_d.error = 1'b0;
        if (!enable)
        begin
            r_d.state = UCS_RL_WAIT_HIGH;
            r_d.count = '0;
        end
        else
        begin
            case (r_q.state)
                UCS_RL_WAIT_HIGH:
                begin
                    // Wait for an idle line so the edge is a real start
                    if (receive_pin)
                        r_d.state = UCS_RL_WAIT_LOW;
                end
                UCS_RL_WAIT_LOW:
                begin
                    // Falling edge opens the start bit
                    if (!receive_pin)
                    begin
                        r_d.state = UCS_RL_MEASURE;
                        r_d.count = '0;
                    end
                end
                UCS_RL_MEASURE:
                begin
                    if (receive_pin)
                    begin
                        // Bit time in cycles, less one, is the divider
                        r_d.done  = 1'b1;
                        r_d.value = r_q.count;
                        r_d.state = UCS_RL_WAIT_HIGH;
                    end
                    else if (&r_q.count)
                    begin
                        // Counter at its limit: time-out
                        r_d.error = 1'b1;
                        r_d.state = UCS_RL_WAIT_HIGH;
                    end
                    else
                        r_d.count = r_q.count + 1'b1;
                end
                default:
                    r_d.state = UCS_RL_WAIT_HIGH;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q.state <= UCS_RL_WAIT_HIGH;
            r_q.count <= '0;
            r_q.done  <= 1'b0;
            r_q.error <= 1'b0;
            r_q.value <= '0;
        end
        else
            r_q <= r_d;
    end

    assign done     = r_q.done;
    assign error    = r_q.error;
    assign measured = r_q.value;

endmodule

/* src/ucs_sync.sv */
`timescale 1ns/1ps
module ucs_sync
    import ucs_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Level in and out
    input  wire logic din,
    output logic      dout
);

    typedef struct packed {
        logic [UCS_SYNC_STAGES-1:0] stage;
    } ucs_sync_t;

    ucs_sync_t s_q;
    ucs_sync_t s_d;

    // Each stage only feeds the next one
    always_comb
    begin
        s_d.stage = {s_q.stage[UCS_SYNC_STAGES-2:0], din};
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign dout = s_q.stage[UCS_SYNC_STAGES-1];

endmodule

/* verification/ucs_flags_assertions.sv */
`timescale 1ns/1ps
module ucs_flags_checker
    import ucs_pkg::*;
#(
    parameter int AW = 12,
    parameter int DW = 16
)
(
    // Clock and reset
    input wire logic          mclk,
    input wire logic          rst_n,
    // Register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic          reg_rd,
    input wire logic [31:0]   reg_rdata,
    // Mode and activity
    input wire logic          sync_mode,
    input wire logic          loopback,
    input wire logic          flow_gate_enable,
    input wire logic          loop_cts,
    input wire logic          rx_busy,
    input wire logic          tx_busy,
    // Outputs
    input wire logic          serial_clk,
    input wire logic          cts_level,
    input wire logic          cts_gate,
    input wire logic          irq_request
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic st_rd;
    assign st_rd = reg_rd && (reg_addr == AW'(UCS_OFF_FLAGS));

    AST_CLK_IDLE: assert property (!sync_mode |=> !serial_clk)
        else $error("serial clock active outside sync mode");
    AST_CLK_CAUSE: assert property ($rose(serial_clk) |->
        $past(sync_mode))
        else $error("serial clock rose without sync mode");
    AST_RX_QUIET: assert property (st_rd |=>
        reg_rdata[UCS_ST_RX_QUIET] == !$past(rx_busy, 2))
        else $error("receiver quiet bit wrong");
    AST_TX_QUIET: assert property (st_rd |=>
        reg_rdata[UCS_ST_TX_QUIET] == !$past(tx_busy, 2))
        else $error("transmitter quiet bit wrong");
    AST_CTS_BIT: assert property (st_rd |=>
        reg_rdata[UCS_ST_CTS_LEVEL] == $past(cts_level, 2))
        else $error("handshake level bit wrong");
    AST_CTS_GATE: assert property (!flow_gate_enable |-> !cts_gate)
        else $error("handshake gate open while disabled");
    AST_GATE_LOOP: assert property (flow_gate_enable && loopback |->
        cts_gate == loop_cts)
        else $error("handshake gate ignores looped value");
    AST_LOOP: assert property (loopback |-> cts_level == loop_cts)
        else $error("looped handshake not used");
    AST_RESERVED: assert property (st_rd |=>
        (reg_rdata & 32'hfffe_0fc5) == 32'h0)
        else $error("reserved status bits not zero");

    cover property ($rose(serial_clk));
    cover property (st_rd);
    cover property ($rose(irq_request));
    cover property (loopback && cts_level);
endmodule

bind ucs_flags ucs_flags_checker #(.AW(AW), .DW(DW)) chk_u (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sync_mode(sync_mode), .loopback(loopback),
    .flow_gate_enable(flow_gate_enable), .loop_cts(loop_cts),
    .rx_busy(rx_busy), .tx_busy(tx_busy), .serial_clk(serial_clk),
    .cts_level(cts_level), .cts_gate(cts_gate), .irq_request(irq_request)
);

/* verification/ucs_flags_tb.sv */
`timescale 1ns/1ps
module ucs_flags_tb;
    import ucs_pkg::*;
    logic        mclk, rst_n, reg_wr, reg_rd;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, r;
    logic        sync_mode, loopback, flow_gate_enable, loop_cts;
    logic        rx_busy, tx_busy, rx_char_done, receive_pin, cts_pin;
    logic [3:0]  ev;
    logic        serial_clk, cts_level, cts_gate, irq_request;
    logic [7:0]  baud_divider;
    int          miscompares, comparisons, cycles, n;

    ucs_flags #(.AW(12), .DW(8)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sync_mode(sync_mode), .loopback(loopback),
        .flow_gate_enable(flow_gate_enable), .loop_cts(loop_cts),
        .rx_busy(rx_busy), .tx_busy(tx_busy), .rx_char_done(rx_char_done),
        .rx_start_seen(ev[0]), .rx_frame_err(ev[1]),
        .rx_parity_err(ev[2]), .rx_noise(ev[3]),
        .receive_pin(receive_pin), .cts_pin(cts_pin),
        .serial_clk(serial_clk), .baud_divider(baud_divider),
        .cts_level(cts_level), .cts_gate(cts_gate), .irq_request(irq_request)
    );
    ucs_remote remote_u (
        .mclk(mclk), .receive_pin(receive_pin), .cts_pin(cts_pin)
    );

    always #5 mclk = ~mclk;

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            conclude();
        end
    end

    task conclude();
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task pulse_ev(input logic [3:0] v, input logic done);
        @(posedge mclk);
        ev           <= v;
        rx_char_done <= done;
        @(posedge mclk);
        ev           <= 4'h0;
        rx_char_done <= 1'b0;
    endtask

    task count_rises(output int k);
        logic p;
        k = 0;
        p = serial_clk;
        repeat (40)
        begin
            @(posedge mclk);
            #1;
            if (serial_clk && !p)
                k = k + 1;
            p = serial_clk;
        end
    endtask

    task t_reset();
        rd(UCS_OFF_FLAGS, r);
        chk(r, 32'h0000_000a);
        rd(UCS_OFF_CONTROL, r);
        chk(r, 32'h0000_0000);
        rd(12'h100, r);
        chk(r, 32'h0000_0000);
    endtask

    task t_activity();
        @(posedge mclk);
        rx_busy <= 1'b1;
        tx_busy <= 1'b1;
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'ha, 32'h0);
        rx_busy <= 1'b0;
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'ha, 32'h2);
        tx_busy <= 1'b0;
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'ha, 32'ha);
    endtask

    task t_cts();
        remote_u.set_cts(1'b1);
        repeat (5) @(posedge mclk);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'h30, 32'h30);
        wr(UCS_OFF_FLAGS, 32'h0);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'h30, 32'h30);
        wr(UCS_OFF_FLAGS, 32'h20);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'h30, 32'h10);
        flow_gate_enable <= 1'b1;
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'h30, 32'h10);
        chk(cts_gate, 32'h1);
        loopback <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'h30, 32'h20);
        chk(cts_level, 32'h0);
        loop_cts <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk(cts_level, 32'h1);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'h10, 32'h10);
        loop_cts         <= 1'b0;
        loopback         <= 1'b0;
        flow_gate_enable <= 1'b0;
        repeat (3) @(posedge mclk);
        wr(UCS_OFF_FLAGS, 32'h20);
    endtask

    task t_errors();
        pulse_ev(4'hf, 1'b0);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'hf000, 32'hf000);
        repeat (10) @(posedge mclk);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'hf000, 32'hf000);
        wr(UCS_OFF_FLAGS, 32'h5000);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'hf000, 32'ha000);
        wr(UCS_OFF_FLAGS, 32'ha000);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'hf000, 32'h0);
    endtask

    task t_clock();
        wr(UCS_OFF_DIVIDER, 32'h1);
        sync_mode <= 1'b1;
        wr(UCS_OFF_CONTROL, 32'h300);
        count_rises(n);
        chk(n, 32'd10);
        pulse_ev(4'h0, 1'b1);
        rd(UCS_OFF_CONTROL, r);
        chk(r, 32'h0);
        count_rises(n);
        chk(n, 32'h0);
        tx_busy <= 1'b1;
        count_rises(n);
        chk(n, 32'd10);
        tx_busy <= 1'b0;
        wr(UCS_OFF_CONTROL, 32'h100);
        pulse_ev(4'h0, 1'b1);
        rd(UCS_OFF_CONTROL, r);
        chk(r, 32'h100);
        sync_mode <= 1'b0;
        wr(UCS_OFF_CONTROL, 32'hfffe_ffff);
        rd(UCS_OFF_CONTROL, r);
        chk(r, 32'h300);
        wr(UCS_OFF_CONTROL, 32'h0);
    endtask

    task t_rate();
        wr(UCS_OFF_CONTROL, 32'h1_0000);
        remote_u.start_bit(20);
        repeat (4) @(posedge mclk);
        rd(UCS_OFF_CONTROL, r);
        chk(r, 32'h0);
        rd(UCS_OFF_DIVIDER, r);
        chk(r, 32'd19);
        chk(baud_divider, 32'd19);
        wr(UCS_OFF_CONTROL, 32'h1_0000);
        remote_u.start_bit(300);
        repeat (4) @(posedge mclk);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'h1_0000, 32'h1_0000);
        rd(UCS_OFF_CONTROL, r);
        chk(r, 32'h0);
        wr(UCS_OFF_FLAGS, 32'h1_0000);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'h1_0000, 32'h0);
    endtask

    task t_irq();
        wr(UCS_OFF_IEN_SET, 32'h8);
        repeat (3) @(posedge mclk);
        #1;
        chk(irq_request, 32'h1);
        wr(UCS_OFF_FLAGS, 32'h8);
        rd(UCS_OFF_FLAGS, r);
        chk(r & 32'h8, 32'h8);
        wr(UCS_OFF_IEN_CLR, 32'h8);
        repeat (3) @(posedge mclk);
        #1;
        chk(irq_request, 32'h0);
        rd(UCS_OFF_IEN_SET, r);
        chk(r, 32'h0);
    endtask

    initial
    begin
        mclk             = 1'b0;
        rst_n            = 1'b0;
        reg_wr           = 1'b0;
        reg_rd           = 1'b0;
        reg_addr         = 12'h000;
        reg_wdata        = 32'h0;
        sync_mode        = 1'b0;
        loopback         = 1'b0;
        flow_gate_enable = 1'b0;
        loop_cts         = 1'b0;
        rx_busy          = 1'b0;
        tx_busy          = 1'b0;
        rx_char_done     = 1'b0;
        ev               = 4'h0;
        miscompares      = 0;
        comparisons      = 0;
        cycles           = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_activity();
        t_cts();
        t_errors();
        t_clock();
        t_rate();
        t_irq();
        conclude();
    end
endmodule

/* verification/ucs_remote.sv */
`timescale 1ns/1ps
module ucs_remote (
    // Clock
    input  wire logic mclk,
    // Line pins
    output logic      receive_pin,
    output logic      cts_pin
);
    initial
    begin
        receive_pin = 1'b1;
        cts_pin     = 1'b0;
    end

    // Start bit of n cycles, then back to the idle high level
    task automatic start_bit(input int n);
        @(posedge mclk);
        receive_pin <= 1'b0;
        repeat (n) @(posedge mclk);
        receive_pin <= 1'b1;
    endtask

    // Handshake changes right after a clock edge
    task automatic set_cts(input logic v);
        @(posedge mclk);
        cts_pin <= v;
    endtask
endmodule
